// file: design/iau_regs.svh
// Purpose: named constants of the integer arithmetic unit
// Assumes: included by the package and by the unit itself
// Notes:   definitions only, guarded against double inclusion
`ifndef IAU_REGS_SVH
`define IAU_REGS_SVH

// data widths
`define IAU_QW        64
`define IAU_LW        32
`define IAU_PW        128
`define IAU_LIT_W     8
`define IAU_DST_W     5
`define IAU_OP_W      5

// field positions
`define IAU_LW_MSB    31
`define IAU_QW_MSB    63
`define IAU_HI_MSB    127
`define IAU_HI_LSB    64

// scale shifts: by 4 and by 8
`define IAU_SH4       2
`define IAU_SH8       3

// reset and compare answers
`define IAU_ZERO_QW   64'h0000_0000_0000_0000
`define IAU_ONE_QW    64'h0000_0000_0000_0001
`define IAU_ZERO_DST  5'h00

// clock: 40 MHz, answer one cycle after issue
`define IAU_CLK_NS    25
`define IAU_LATENCY   1

`endif

// file: design/iau_pkg.sv
// Purpose: types shared by the integer arithmetic unit and its bench
// Assumes: constants come from iau_regs.svh
// Notes:   operation codes above the last listed one are illegal
`include "iau_regs.svh"

package iau_pkg;

  // operation selector from decode
  typedef enum logic [`IAU_OP_W-1:0] {
    OP_ADD_LONG, OP_SCALE4_ADD_LONG, OP_SCALE8_ADD_LONG,
    OP_ADD_QUAD, OP_SCALE4_ADD_QUAD, OP_SCALE8_ADD_QUAD,
    OP_SUBTRACT_LONG, OP_SCALE4_SUBTRACT_LONG, OP_SCALE8_SUBTRACT_LONG,
    OP_SUBTRACT_QUAD, OP_SCALE4_SUBTRACT_QUAD, OP_SCALE8_SUBTRACT_QUAD,
    OP_COMPARE_EQUAL, OP_COMPARE_SIGNED_LESS, OP_COMPARE_SIGNED_LESS_EQUAL,
    OP_COMPARE_UNSIGNED_LESS, OP_COMPARE_UNSIGNED_LESS_EQUAL,
    OP_MULTIPLY_LONG, OP_MULTIPLY_QUAD, OP_UNSIGNED_MULTIPLY_HIGH
  } iau_op_e;

  // one issued operation
  typedef struct packed {
    iau_op_e                   op;
    logic                      ovf_enable;
    logic                      literal_sel;
    logic [`IAU_LIT_W-1:0]     literal;
    logic [`IAU_QW-1:0]        first_source;
    logic [`IAU_QW-1:0]        second_source;
    logic [`IAU_DST_W-1:0]     destination;
  } iau_req_s;

  // one finished operation
  typedef struct packed {
    logic [`IAU_DST_W-1:0]     destination;
    logic [`IAU_QW-1:0]        value;
    logic                      overflow;
    logic                      illegal;
  } iau_rsp_s;

endpackage

// file: design/iau_top.sv
// Purpose: integer add, subtract, compare and multiply execution unit
// Assumes: decode drives req on clk_sys; one answer per issue, one cycle later
// Notes:   purely combinational datapath into one output register stage
//
// What this block does
// - longword add: sign-extend low 32-bit sum
// - longword ops ignore upper halves, judge bits 31:0
// - scaled longword add: shift 2/3, no overflow
// - quadword add writes full 64-bit sum
// - quadword overflow still writes low 64 bits
// - scaled quadword add: shift 2/3, no overflow
// - signed compares: equal, less, less-equal only
// - compare writes one when true, else zero
// - unsigned less and less-equal compares
// - longword multiply: sign-extended low 32, overflow checked
// - quadword multiply overflows when signed product exceeds
// - unsigned multiply-high writes product bits 127:64
// - longword subtract: sign-extend low 32-bit difference
// - scaled longword subtract: shift 2/3, no overflow
// - quadword subtract writes 64-bit difference
// - scaled quadword subtract: shift 2/3, no overflow
// - overflow raised only with overflow-enable qualifier
// - second operand from register or literal
// - no divide operation offered
`timescale 1ns/10ps
`include "iau_regs.svh"

module iau_top (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             req_valid,
  input  wire iau_pkg::iau_req_s req,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output iau_pkg::iau_rsp_s     rsp
);
  import iau_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // sign-extend a longword into a quadword
  function automatic logic [`IAU_QW-1:0] sext_long(input logic [`IAU_LW-1:0] x);
    sext_long = {{(`IAU_QW-`IAU_LW){x[`IAU_LW_MSB]}}, x};
  endfunction

  // overflow of a two's complement sum from the three sign bits
  function automatic logic sum_ovf(input logic sa, input logic sb, input logic ss);
    sum_ovf = (sa == sb) && (ss != sa);
  endfunction

  // overflow of a two's complement difference a - b
  function automatic logic diff_ovf(input logic sa, input logic sb, input logic sd);
    diff_ovf = (sa != sb) && (sd != sa);
  endfunction

  // scale a quadword by 4 or by 8, upper bits simply drop off
  function automatic logic [`IAU_QW-1:0] scale_quad(input logic [`IAU_QW-1:0] x,
                                                    input logic              by8);
    scale_quad = by8 ? (x << `IAU_SH8) : (x << `IAU_SH4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand selection

  logic [`IAU_QW-1:0]  opa;
  logic [`IAU_QW-1:0]  opb;
  logic [`IAU_LW-1:0]  opa_l;
  logic [`IAU_LW-1:0]  opb_l;

  // literal is zero-extended; register path otherwise
  assign opa   = req.first_source;
  assign opb   = req.literal_sel ? {{(`IAU_QW-`IAU_LIT_W){1'b0}}, req.literal}
                                 : req.second_source;
  assign opa_l = opa[`IAU_LW_MSB:0];
  assign opb_l = opb[`IAU_LW_MSB:0];

  // never stalls: one operation per enabled cycle
  assign req_ready = clk_en;

  ////////////////////////////////////////////////////////////////////////////
  // adders and subtractors

  logic [`IAU_LW-1:0]  sum_l;
  logic [`IAU_LW-1:0]  dif_l;
  logic [`IAU_LW-1:0]  s4sum_l;
  logic [`IAU_LW-1:0]  s8sum_l;
  logic [`IAU_LW-1:0]  s4dif_l;
  logic [`IAU_LW-1:0]  s8dif_l;
  logic [`IAU_QW-1:0]  sum_q;
  logic [`IAU_QW-1:0]  dif_q;
  logic [`IAU_QW-1:0]  s4sum_q;
  logic [`IAU_QW-1:0]  s8sum_q;
  logic [`IAU_QW-1:0]  s4dif_q;
  logic [`IAU_QW-1:0]  s8dif_q;

  // longword forms work on the low halves only, wrap is intended
  assign sum_l   = opa_l + opb_l;
  assign dif_l   = opa_l - opb_l;
  assign s4sum_l = (opa_l << `IAU_SH4) + opb_l;
  assign s8sum_l = (opa_l << `IAU_SH8) + opb_l;
  assign s4dif_l = (opa_l << `IAU_SH4) - opb_l;
  assign s8dif_l = (opa_l << `IAU_SH8) - opb_l;

  // quadword forms keep the low 64 bits of the true result
  assign sum_q   = opa + opb;
  assign dif_q   = opa - opb;
  assign s4sum_q = scale_quad(opa, 1'b0) + opb;
  assign s8sum_q = scale_quad(opa, 1'b1) + opb;
  assign s4dif_q = scale_quad(opa, 1'b0) - opb;
  assign s8dif_q = scale_quad(opa, 1'b1) - opb;

  ////////////////////////////////////////////////////////////////////////////
  // multipliers

  logic signed [`IAU_QW-1:0] mul_l;
  logic signed [`IAU_PW-1:0] mul_q;
  logic        [`IAU_PW-1:0] mul_u;
  logic                      mul_l_ovf;
  logic                      mul_q_ovf;

  // operands widened first so the products come out at full width
  assign mul_l = $signed({{(`IAU_QW-`IAU_LW){opa_l[`IAU_LW_MSB]}}, opa_l})
               * $signed({{(`IAU_QW-`IAU_LW){opb_l[`IAU_LW_MSB]}}, opb_l});
  assign mul_q = $signed({{(`IAU_PW-`IAU_QW){opa[`IAU_QW_MSB]}}, opa})
               * $signed({{(`IAU_PW-`IAU_QW){opb[`IAU_QW_MSB]}}, opb});
  assign mul_u = {{(`IAU_PW-`IAU_QW){1'b0}}, opa}
               * {{(`IAU_PW-`IAU_QW){1'b0}}, opb};

  // product fits only if everything above the result sign copies it
  assign mul_l_ovf = (mul_l[`IAU_QW_MSB:`IAU_LW_MSB] != {(`IAU_QW-`IAU_LW+1){1'b0}})
                  && (mul_l[`IAU_QW_MSB:`IAU_LW_MSB] != {(`IAU_QW-`IAU_LW+1){1'b1}});
  assign mul_q_ovf = (mul_q[`IAU_HI_MSB:`IAU_QW_MSB] != {(`IAU_PW-`IAU_QW+1){1'b0}})
                  && (mul_q[`IAU_HI_MSB:`IAU_QW_MSB] != {(`IAU_PW-`IAU_QW+1){1'b1}});

  ////////////////////////////////////////////////////////////////////////////
  // result select

  logic [`IAU_QW-1:0]  value_next;
  logic                ovf_raw;
  logic                illegal_next;
  logic                ovf_next;

  // one case per operation; scaled forms and compares leave ovf_raw low
  always_comb begin
    value_next   = `IAU_ZERO_QW;
    ovf_raw      = 1'b0;
    illegal_next = 1'b0;
    unique case (req.op)
      OP_ADD_LONG: begin
        value_next = sext_long(sum_l);
        ovf_raw    = sum_ovf(opa_l[`IAU_LW_MSB], opb_l[`IAU_LW_MSB],
                             sum_l[`IAU_LW_MSB]);
      end
      OP_SCALE4_ADD_LONG:       value_next = sext_long(s4sum_l);
      OP_SCALE8_ADD_LONG:       value_next = sext_long(s8sum_l);
      OP_ADD_QUAD: begin
        value_next = sum_q;
        ovf_raw    = sum_ovf(opa[`IAU_QW_MSB], opb[`IAU_QW_MSB], sum_q[`IAU_QW_MSB]);
      end
      OP_SCALE4_ADD_QUAD:       value_next = s4sum_q;
      OP_SCALE8_ADD_QUAD:       value_next = s8sum_q;
      OP_SUBTRACT_LONG: begin
        value_next = sext_long(dif_l);
        ovf_raw    = diff_ovf(opa_l[`IAU_LW_MSB], opb_l[`IAU_LW_MSB],
                              dif_l[`IAU_LW_MSB]);
      end
      OP_SCALE4_SUBTRACT_LONG:  value_next = sext_long(s4dif_l);
      OP_SCALE8_SUBTRACT_LONG:  value_next = sext_long(s8dif_l);
      OP_SUBTRACT_QUAD: begin
        value_next = dif_q;
        ovf_raw    = diff_ovf(opa[`IAU_QW_MSB], opb[`IAU_QW_MSB], dif_q[`IAU_QW_MSB]);
      end
      OP_SCALE4_SUBTRACT_QUAD:  value_next = s4dif_q;
      OP_SCALE8_SUBTRACT_QUAD:  value_next = s8dif_q;
      // greater-than forms come from software swapping operands
      OP_COMPARE_EQUAL:
        value_next = (opa == opb) ? `IAU_ONE_QW : `IAU_ZERO_QW;
      OP_COMPARE_SIGNED_LESS:
        value_next = ($signed(opa) < $signed(opb)) ? `IAU_ONE_QW : `IAU_ZERO_QW;
      OP_COMPARE_SIGNED_LESS_EQUAL:
        value_next = ($signed(opa) <= $signed(opb)) ? `IAU_ONE_QW : `IAU_ZERO_QW;
      OP_COMPARE_UNSIGNED_LESS:
        value_next = (opa < opb) ? `IAU_ONE_QW : `IAU_ZERO_QW;
      OP_COMPARE_UNSIGNED_LESS_EQUAL:
        value_next = (opa <= opb) ? `IAU_ONE_QW : `IAU_ZERO_QW;
      OP_MULTIPLY_LONG: begin
        value_next = sext_long(mul_l[`IAU_LW_MSB:0]);
        ovf_raw    = mul_l_ovf;
      end
      OP_MULTIPLY_QUAD: begin
        value_next = mul_q[`IAU_QW_MSB:0];
        ovf_raw    = mul_q_ovf;
      end
      OP_UNSIGNED_MULTIPLY_HIGH:
        value_next = mul_u[`IAU_HI_MSB:`IAU_HI_LSB];
      // spare codes (a divide among them) are refused, value zero
      default:
        illegal_next = 1'b1;
    endcase
  end

  // trap only when decode passed the overflow-enable qualifier
  assign ovf_next = ovf_raw && req.ovf_enable;

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  logic      rsp_valid_reg;
  iau_rsp_s  rsp_reg;

  // answer strobe: follows issue by one enabled edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_reg <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_reg <= req_valid;
    end
  end

  // answer payload: held between issues, no other state kept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg <= '{destination: `IAU_ZERO_DST, value: `IAU_ZERO_QW,
                   overflow: 1'b0, illegal: 1'b0};
    end else if (clk_en && req_valid) begin
      rsp_reg.destination <= req.destination;
      rsp_reg.value       <= value_next;
      rsp_reg.overflow    <= ovf_next;
      rsp_reg.illegal     <= illegal_next;
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp       = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // an accepted operation of a given kind
  sequence s_issue(iau_op_e o);
    req_valid && clk_en && req.op == o;
  endsequence

  // the answer edge one cycle on
  sequence s_answer;
    ##`IAU_LATENCY rsp_valid;
  endsequence

  // checker-side results formed straight from the request, not from the datapath
  logic [`IAU_LW-1:0]  chk_dif_l;
  logic [`IAU_QW-1:0]  chk_mul_l;
  logic [`IAU_PW-1:0]  chk_mul_q;

  // both product operands widened on purpose so nothing is padded silently
  assign chk_dif_l = req.first_source[`IAU_LW_MSB:0] - req.second_source[`IAU_LW_MSB:0];
  assign chk_mul_l = $signed(sext_long(req.first_source[`IAU_LW_MSB:0]))
                   * $signed(sext_long(req.second_source[`IAU_LW_MSB:0]));
  assign chk_mul_q = $signed({{`IAU_QW{req.first_source[`IAU_QW_MSB]}}, req.first_source})
                   * $signed({{`IAU_QW{req.second_source[`IAU_QW_MSB]}}, req.second_source});

  a_long_add_sext:
    assert property (s_issue(OP_ADD_LONG) ##0 !req.literal_sel |-> s_answer ##0
      rsp.value == sext_long($past(req.first_source[31:0] + req.second_source[31:0])))
    else $error("longword add result not sign-extended sum");

  a_long_ovf_low:
    assert property (s_issue(OP_SUBTRACT_LONG) ##0 (req.ovf_enable && !req.literal_sel) |=>
      rsp.overflow == diff_ovf($past(req.first_source[31]), $past(req.second_source[31]),
                               $past(chk_dif_l[`IAU_LW_MSB])))
    else $error("longword subtract overflow not judged on low bits");

  a_scaled_long:
    assert property (s_issue(OP_SCALE8_ADD_LONG) ##0 !req.literal_sel |=> !rsp.overflow &&
      rsp.value == sext_long($past((req.first_source[31:0] << 3) + req.second_source[31:0])))
    else $error("scale8 longword add wrong");

  a_quad_add_full:
    assert property (s_issue(OP_ADD_QUAD) ##0 !req.literal_sel |=>
      rsp.value == $past(req.first_source + req.second_source))
    else $error("quadword add result wrong");

  a_quad_mul_wrap:
    assert property (s_issue(OP_MULTIPLY_QUAD) ##0 !req.literal_sel |=>
      rsp.value == $past(req.first_source * req.second_source))
    else $error("quadword multiply low bits wrong");

  a_scaled_quad:
    assert property (s_issue(OP_SCALE4_SUBTRACT_QUAD) ##0 !req.literal_sel |=> !rsp.overflow &&
      rsp.value == $past((req.first_source << 2) - req.second_source))
    else $error("scale4 quadword subtract wrong");

  a_signed_less:
    assert property (s_issue(OP_COMPARE_SIGNED_LESS) ##0 !req.literal_sel |=>
      rsp.value[0] == $past($signed(req.first_source) < $signed(req.second_source)))
    else $error("signed less compare wrong");

  a_compare_bool:
    assert property ((s_issue(OP_COMPARE_EQUAL) or s_issue(OP_COMPARE_UNSIGNED_LESS_EQUAL))
      |-> s_answer ##0 rsp.value[63:1] == '0 && !rsp.overflow)
    else $error("compare result not one or zero");

  a_unsigned_less:
    assert property (s_issue(OP_COMPARE_UNSIGNED_LESS) ##0 !req.literal_sel |=>
      rsp.value[0] == $past(req.first_source < req.second_source))
    else $error("unsigned less compare wrong");

  a_unsigned_multiply_high_high:
    assert property (s_issue(OP_UNSIGNED_MULTIPLY_HIGH) |=> !rsp.overflow && !rsp.illegal)
    else $error("multiply-high raised an exception");

  a_ovf_gated:
    assert property (req_valid && clk_en && !req.ovf_enable |=> !rsp.overflow)
    else $error("overflow raised without enable qualifier");

  a_literal_path:
    assert property (s_issue(OP_ADD_QUAD) ##0 req.literal_sel |=>
      rsp.value == $past(req.first_source + {56'h0, req.literal}))
    else $error("literal operand not used");

  a_no_divide:
    assert property (req_valid && clk_en && req.op > OP_UNSIGNED_MULTIPLY_HIGH |=>
      rsp.illegal && rsp.value == '0 && !rsp.overflow)
    else $error("spare operation code not refused");

  a_no_flags:
    assert property (!(req_valid && clk_en) |=> $stable(rsp))
    else $error("answer changed without an issue");

  a_long_mul_wrap:
    assert property (s_issue(OP_MULTIPLY_LONG) ##0 (req.ovf_enable && !req.literal_sel) |=>
      rsp.value == sext_long($past(chk_mul_l[`IAU_LW_MSB:0]))
      && rsp.overflow == $past(chk_mul_l != sext_long(chk_mul_l[`IAU_LW_MSB:0])))
    else $error("longword multiply result or overflow wrong");

  a_quad_mul_ovf:
    assert property (s_issue(OP_MULTIPLY_QUAD) ##0 (req.ovf_enable && !req.literal_sel) |=>
      rsp.overflow == $past(chk_mul_q != {{`IAU_QW{chk_mul_q[`IAU_QW_MSB]}},
                                          chk_mul_q[`IAU_QW_MSB:0]}))
    else $error("quadword multiply overflow wrong");

  a_long_sub:
    assert property (s_issue(OP_SUBTRACT_LONG) ##0 !req.literal_sel |=>
      rsp.value == sext_long($past(chk_dif_l)))
    else $error("longword subtract result wrong");

  a_quad_sub:
    assert property (s_issue(OP_SUBTRACT_QUAD) ##0 !req.literal_sel |=>
      rsp.value == $past(req.first_source - req.second_source))
    else $error("quadword subtract result wrong");

endmodule

// file: dv/iau_issue_model.sv
// Purpose: decode and register-file side that feeds the arithmetic unit
// Assumes: requests change one small delay after the rising clk_sys edge
// Notes:   a released request bus shows inverted data, never the old value
`timescale 1ns/10ps

module iau_issue_model (
  input  wire logic         clk_sys,
  output iau_pkg::iau_req_s req,
  output logic              req_valid
);
  import iau_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold one request over exactly one taking edge, then return settled
  task automatic issue(input iau_req_s r);
    req_valid = 1'b1;
    req       = r;
    @(posedge clk_sys);
    #1;
  endtask

  // release the bus; inverted data so a stale operand cannot look valid
  task automatic idle();
    req_valid = 1'b0;
    req       = ~req;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// file: dv/test_integer_arith_unit.sv
// Purpose: self-checking bench for the integer arithmetic unit
// Assumes: one answer exactly one enabled cycle after each taken request
// Notes:   expected results come from an independent reference function
`timescale 1ns/10ps

module test_integer_arith_unit;
  import iau_pkg::*;

  logic              clk_sys;
  logic              rst_n;
  logic              clk_en;
  logic              req_valid;
  logic              req_ready;
  logic              rsp_valid;
  iau_req_s          req;
  iau_rsp_s          rsp;
  int                err_total;
  int                comparisons;
  logic [63:0]       op_a [6] = '{64'h7FFF_FFFF_FFFF_FFFF, 64'h8000_0000_0000_0000,
                                  64'hDEAD_0000_7FFF_FFFF, 64'h0000_0001_0000_0000,
                                  64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_0000_0001_0000};
  logic [63:0]       op_b [6] = '{64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001,
                                  64'h1234_5678_0000_0001, 64'h0000_0001_0000_0000,
                                  64'h0000_0000_0000_0002, 64'h0000_0000_0001_0000};

  iau_top i_dut (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .rsp_valid (rsp_valid),
    .rsp       (rsp)
  );

  iau_issue_model i_model (
    .clk_sys   (clk_sys),
    .req       (req),
    .req_valid (req_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [63:0] sx(input logic [31:0] x);
    return {{32{x[31]}}, x};
  endfunction

  // reference: {overflow, value}; 128-bit products keep the exact result
  function automatic logic [64:0] calc(input iau_op_e op, input logic en,
                                       input logic [63:0] a, input logic [63:0] b);
    logic [63:0]  v;
    logic         o;
    logic [63:0]  pl;
    logic [127:0] pq;
    logic [127:0] pu;
    pl = {{32{a[31]}}, a[31:0]} * {{32{b[31]}}, b[31:0]};
    pq = {{64{a[63]}}, a} * {{64{b[63]}}, b};
    pu = {64'h0, a} * {64'h0, b};
    o  = 1'b0;
    v  = 64'h0;
    case (op)
      OP_ADD_LONG: begin
        v = sx(a[31:0] + b[31:0]);
        o = (a[31] == b[31]) && (v[31] != a[31]);
      end
      OP_SUBTRACT_LONG: begin
        v = sx(a[31:0] - b[31:0]);
        o = (a[31] != b[31]) && (v[31] != a[31]);
      end
      OP_ADD_QUAD: begin
        v = a + b;
        o = (a[63] == b[63]) && (v[63] != a[63]);
      end
      OP_SUBTRACT_QUAD: begin
        v = a - b;
        o = (a[63] != b[63]) && (v[63] != a[63]);
      end
      OP_SCALE4_ADD_LONG:             v = sx(a[29:0] * 4 + b[31:0]);
      OP_SCALE8_ADD_LONG:             v = sx(a[28:0] * 8 + b[31:0]);
      OP_SCALE4_SUBTRACT_LONG:        v = sx(a[29:0] * 4 - b[31:0]);
      OP_SCALE8_SUBTRACT_LONG:        v = sx(a[28:0] * 8 - b[31:0]);
      OP_SCALE4_ADD_QUAD:             v = (a << 2) + b;
      OP_SCALE8_ADD_QUAD:             v = (a << 3) + b;
      OP_SCALE4_SUBTRACT_QUAD:        v = (a << 2) - b;
      OP_SCALE8_SUBTRACT_QUAD:        v = (a << 3) - b;
      OP_COMPARE_EQUAL:               v = {63'h0, a == b};
      OP_COMPARE_SIGNED_LESS:         v = {63'h0, $signed(a) < $signed(b)};
      OP_COMPARE_SIGNED_LESS_EQUAL:   v = {63'h0, $signed(a) <= $signed(b)};
      OP_COMPARE_UNSIGNED_LESS:       v = {63'h0, a < b};
      OP_COMPARE_UNSIGNED_LESS_EQUAL: v = {63'h0, a <= b};
      OP_MULTIPLY_LONG: begin
        v = sx(pl[31:0]);
        o = pl[63:32] != {32{pl[31]}};
      end
      OP_MULTIPLY_QUAD: begin
        v = pq[63:0];
        o = pq[127:64] != {64{pq[63]}};
      end
      OP_UNSIGNED_MULTIPLY_HIGH:      v = pu[127:64];
      default:                        v = 64'h0;
    endcase
    return {o & en, v};
  endfunction

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // issue one operation and judge the answer on the following edge
  task automatic run_op(input logic [4:0] code, input logic en, input logic lsel,
                        input logic [7:0] lit, input logic [63:0] a, input logic [63:0] b);
    iau_req_s    r;
    logic [64:0] e;
    r = '{op: iau_op_e'(code), ovf_enable: en, literal_sel: lsel, literal: lit,
          first_source: a, second_source: b, destination: code ^ 5'h15};
    e = calc(r.op, en, a, lsel ? {56'h0, lit} : b);
    i_model.issue(r);
    check(rsp_valid === 1'b1 && rsp.value === e[63:0] && rsp.overflow === e[64]
          && rsp.destination === r.destination && rsp.illegal === 1'b0, "result");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // back-to-back sweep of codes lo..hi over the operand table
  task automatic sweep(input int lo, input int hi, input logic lsel);
    for (int p = 0; p < 6; p++) begin
      for (int en = 0; en < 2; en++) begin
        for (int k = lo; k <= hi; k++) begin
          run_op(5'(k), 1'(en), lsel, 8'hFF, op_a[p], op_b[p]);
        end
      end
    end
    i_model.idle();
    check(rsp_valid === 1'b0, "answer valid longer than one cycle");
    $display("test sweep %0d..%0d done", lo, hi);
  endtask

  // spare codes answer illegal with zero value and no overflow
  task automatic t_illegal();
    iau_req_s r;
    for (int k = 20; k < 32; k++) begin
      r = '{op: iau_op_e'(5'(k)), ovf_enable: 1'b1, literal_sel: 1'b0, literal: 8'h00,
            first_source: 64'h7FFF_FFFF_FFFF_FFFF, second_source: 64'h1, destination: 5'h1F};
      i_model.issue(r);
      check(rsp.illegal === 1'b1 && rsp.value === 64'h0 && rsp.overflow === 1'b0, "spare");
    end
    i_model.idle();
    $display("test illegal done");
  endtask

  // low enable freezes the answer and refuses new requests
  task automatic t_freeze();
    iau_req_s r;
    r = '{op: OP_SUBTRACT_QUAD, ovf_enable: 1'b0, literal_sel: 1'b0, literal: 8'h00,
          first_source: 64'h5, second_source: 64'h7, destination: 5'h0A};
    run_op(5'(OP_ADD_QUAD), 1'b1, 1'b0, 8'h00, 64'h5, 64'h7);
    clk_en = 1'b0;
    // offered while frozen: must not be taken, the old answer stays
    i_model.issue(r);
    check(req_ready === 1'b0 && rsp_valid === 1'b1 && rsp.value === 64'hC, "frozen");
    clk_en = 1'b1;
    i_model.idle();
    check(rsp_valid === 1'b0 && rsp.value === 64'hC, "hold after answer");
    run_op(5'(OP_SUBTRACT_QUAD), 1'b0, 1'b0, 8'h00, 64'h5, 64'h7);
    $display("test freeze done");
  endtask

  // reset in mid-run clears the answer, and work resumes after release
  task automatic t_reset();
    run_op(5'(OP_ADD_QUAD), 1'b0, 1'b0, 8'h00, 64'h1, 64'h2);
    rst_n = 1'b0;
    #2;
    check(rsp_valid === 1'b0 && rsp === '0, "reset clear");
    i_model.idle();
    rst_n = 1'b1;
    run_op(5'(OP_MULTIPLY_QUAD), 1'b1, 1'b0, 8'h00, 64'h3, 64'h4);
    $display("test reset done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_total   = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    clk_en      = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    sweep(0, 11, 1'b0);
    sweep(12, 19, 1'b0);
    sweep(0, 19, 1'b1);
    t_illegal();
    t_freeze();
    t_reset();
    tally_and_finish();
  end

  // watchdog well beyond the roughly 510 cycles of the tests
  initial begin
    #(25 * 5000);
    err_total++;
    tally_and_finish();
  end
endmodule
